// file: serial_core_model.sv
// Purpose: serial core stand-in on the word ports
// Assumes: same clock as the register block
// Notes: stall holds off transmit words; released rx data shows its inverse
`default_nettype none
module serial_core_model
  import serial_regs_pkg::*;
(
  input wire logic clk,
  input wire logic tx_valid,
  input wire logic [DATA_WIDTH-1:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [DATA_WIDTH-1:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stall = 1'b0;
  logic [DATA_WIDTH-1:0] got[$];
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = '0;
  end
  always @(posedge clk) begin
    tx_ready <= !stall;
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  task automatic send(input logic [DATA_WIDTH-1:0] v);
    rx_valid <= 1'b1;
    rx_data <= v;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~v;
  endtask
endmodule
`default_nettype wire

// file: serial_irq_enable_clear_and_data.sv
// Purpose: register side of a serial port: interrupt enables and data register
// Assumes: avalon-mm slave, 32-bit data, 40 MHz clock, synchronous reset
// Notes: transmit words queue in a two-entry buffer toward the serial core
//
// What this block does
// - writing zero leaves enable unchanged
// - bit 7 one clears error enable
// - bit 5 one clears receive-break enable
// - bit 4 one clears cts-change enable
// - bit 3 one clears receive-start enable
// - set and clear share enables; read back
// - enables read zero after reset
// - data read returns receive buffer
// - data write loads transmit buffer
`default_nettype none
module serial_irq_enable_clear_and_data
  import serial_regs_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_SRST,
  input wire logic [7:0] I_ADDRESS,
  input wire logic I_READ,
  input wire logic I_WRITE,
  input wire logic [31:0] I_WRITEDATA,
  input wire logic [3:0] I_BYTEENABLE,
  output logic [31:0] O_READDATA,
  output logic O_WAITREQUEST,
  output logic [1:0] O_RESPONSE,
  output logic O_TX_VALID,
  output logic [DATA_WIDTH-1:0] O_TX_DATA,
  input wire logic I_TX_READY,
  input wire logic I_RX_VALID,
  input wire logic [DATA_WIDTH-1:0] I_RX_DATA,
  input wire logic I_EVT_RX_START,
  input wire logic I_EVT_CTS_CHANGE,
  input wire logic I_EVT_RX_BREAK,
  input wire logic I_EVT_ERROR,
  input wire logic I_EVT_TX_DONE,
  output logic O_IRQ_ENABLE_ERROR,
  output logic [7:0] O_IRQ_ENABLE
);
  logic [7:0] irq_enable;
  logic [7:0] irq_flag;
  logic [DATA_WIDTH-1:0] rx_word;
  logic rx_full;
  logic answered;
  logic req;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] next_readdata;
  logic [1:0] next_response;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [DATA_WIDTH-1:0] buf_out_data;
  logic tx_push;
  logic tx_sent;
  logic [7:0] wr_byte0;
  logic [15:0] wr_half;
  events_s evt;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_IRQ_ENABLE_CLEAR) || (a == OFS_IRQ_ENABLE_SET) ||
                (a == OFS_IRQ_FLAG) || (a == OFS_SERIAL_DATA);
  endfunction

  // one-wait-state slave: request taken the cycle after it appears
  assign req = (I_READ || I_WRITE) && !answered;
  assign wr_hit = I_WRITE && !answered;
  assign rd_hit = I_READ && !answered;
  assign wr_byte0 = I_BYTEENABLE[0] ? I_WRITEDATA[7:0] : 8'h00;
  assign wr_half = {I_BYTEENABLE[1] ? I_WRITEDATA[15:8] : 8'h00, wr_byte0};
  assign evt = '{rx_start: I_EVT_RX_START, cts_change: I_EVT_CTS_CHANGE,
                 rx_break: I_EVT_RX_BREAK, error: I_EVT_ERROR, tx_done: I_EVT_TX_DONE};
  assign tx_push = wr_hit && (I_ADDRESS == OFS_SERIAL_DATA) && I_BYTEENABLE[0];
  assign tx_sent = buf_out_valid && I_TX_READY;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      answered <= 1'b0;
      O_WAITREQUEST <= 1'b1;
    end else begin
      answered <= req;
      O_WAITREQUEST <= !req;
    end
  end

  // single shared enable store: no read-modify-write needed to clear one source
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      irq_enable <= ENABLE_RESET;
    end else if (wr_hit && I_ADDRESS == OFS_IRQ_ENABLE_CLEAR) begin
      irq_enable <= irq_enable & ~(wr_byte0 & ENABLE_IMPL_MASK);
    end else if (wr_hit && I_ADDRESS == OFS_IRQ_ENABLE_SET) begin
      irq_enable <= irq_enable | (wr_byte0 & ENABLE_IMPL_MASK);
    end
  end

  // sticky event flags; a new event wins over a software clear in the same cycle
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      irq_flag <= ENABLE_RESET;
    end else begin
      logic [7:0] clr;
      logic [7:0] set;
      clr = (wr_hit && I_ADDRESS == OFS_IRQ_FLAG) ? wr_byte0 : 8'h00;
      set = 8'h00;
      set[BIT_RX_START] = evt.rx_start;
      set[BIT_CTS_CHANGE] = evt.cts_change;
      set[BIT_RX_BREAK] = evt.rx_break;
      set[BIT_ERROR] = evt.error;
      set[BIT_TX_DONE] = evt.tx_done;
      irq_flag <= ((irq_flag & ~clr) | set) & ENABLE_IMPL_MASK & ~8'h05;
    end
  end

  // receive holding register; a word arriving while full overwrites the old one
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      rx_word <= DATA_RESET[DATA_WIDTH-1:0];
      rx_full <= 1'b0;
    end else if (I_RX_VALID) begin
      rx_word <= I_RX_DATA;
      rx_full <= 1'b1;
    end else if (rd_hit && I_ADDRESS == OFS_SERIAL_DATA) begin
      rx_full <= 1'b0;
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    next_response = 2'b00;
    if (!is_mapped(I_ADDRESS)) begin
      next_response = 2'b10;
    end else if (I_READ) begin
      unique case (I_ADDRESS)
        OFS_IRQ_ENABLE_CLEAR, OFS_IRQ_ENABLE_SET: begin
          next_readdata[7:0] = irq_enable & ENABLE_IMPL_MASK;
        end
        OFS_IRQ_FLAG: begin
          next_readdata[7:0] = irq_flag;
          next_readdata[BIT_EMPTY] = buf_in_ready;
          next_readdata[BIT_RX_DONE] = rx_full;
        end
        OFS_SERIAL_DATA: begin
          next_readdata[DATA_WIDTH-1:0] = rx_word;
        end
        default: begin
          next_readdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_READDATA <= 32'h0000_0000;
      O_RESPONSE <= 2'b00;
    end else if (req) begin
      O_READDATA <= next_readdata;
      O_RESPONSE <= next_response;
    end
  end

  // a write when the buffer is full is dropped; software waits for the empty flag
  word_buffer #(
    .WIDTH(DATA_WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_tx_buffer (
    .clk(I_SYS_CLK),
    .srst(I_SRST),
    .i_valid(tx_push),
    .i_data(wr_half[DATA_WIDTH-1:0]),
    .o_ready(buf_in_ready),
    .o_valid(buf_out_valid),
    .o_data(buf_out_data),
    .i_ready(tx_sent || !O_TX_VALID)
  );

  // output stage register so the core sees flip-flop driven data
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_TX_VALID <= 1'b0;
      O_TX_DATA <= DATA_RESET[DATA_WIDTH-1:0];
    end else if (!O_TX_VALID || I_TX_READY) begin
      O_TX_VALID <= buf_out_valid;
      O_TX_DATA <= buf_out_data;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_IRQ_ENABLE <= ENABLE_RESET;
      O_IRQ_ENABLE_ERROR <= 1'b0;
    end else begin
      O_IRQ_ENABLE <= irq_enable;
      O_IRQ_ENABLE_ERROR <= irq_enable[BIT_ERROR];
    end
  end
endmodule
`default_nettype wire

// file: serial_irq_enable_clear_and_data_monitor.sv
// Purpose: port assertions for the serial register block
// Assumes: enable copy lags the enable register by one cycle
// Notes: bound to every instance
`default_nettype none
module serial_irq_enable_clear_and_data_monitor
  import serial_regs_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_SRST,
  input wire logic [7:0] I_ADDRESS,
  input wire logic I_READ,
  input wire logic I_WRITE,
  input wire logic [31:0] I_WRITEDATA,
  input wire logic [31:0] O_READDATA,
  input wire logic O_WAITREQUEST,
  input wire logic O_TX_VALID,
  input wire logic [DATA_WIDTH-1:0] O_TX_DATA,
  input wire logic I_TX_READY,
  input wire logic O_IRQ_ENABLE_ERROR,
  input wire logic [7:0] O_IRQ_ENABLE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);
  wire wr_c = I_WRITE && !O_WAITREQUEST && I_ADDRESS == OFS_IRQ_ENABLE_CLEAR;
  wire wr_s = I_WRITE && !O_WAITREQUEST && I_ADDRESS == OFS_IRQ_ENABLE_SET;
  wire rd_c = I_READ && !O_WAITREQUEST && I_ADDRESS == OFS_IRQ_ENABLE_CLEAR;
  clear_ones_a: assert property (
    wr_c |-> ##2 (O_IRQ_ENABLE & $past(I_WRITEDATA[7:0], 2)) == 8'h00) else $error("clear missed");
  clear_zeros_a: assert property (
    wr_c |-> ##2 O_IRQ_ENABLE == ($past(O_IRQ_ENABLE, 2) & ~$past(I_WRITEDATA[7:0], 2)))
    else $error("clear disturbed other enables");
  set_merge_a: assert property (
    wr_s |-> ##2 O_IRQ_ENABLE ==
      ($past(O_IRQ_ENABLE, 2) | ($past(I_WRITEDATA[7:0], 2) & 8'hbf)))
    else $error("set not shared");
  rsvd_zero_a: assert property (O_IRQ_ENABLE[BIT_RESERVED] == 1'b0) else $error("bit 6 set");
  err_copy_a: assert property (O_IRQ_ENABLE_ERROR == O_IRQ_ENABLE[BIT_ERROR])
    else $error("error enable copy off");
  err_clear_a: assert property (
    wr_c && I_WRITEDATA[BIT_ERROR] |-> ##2 !O_IRQ_ENABLE_ERROR)
    else $error("error enable not cleared");
  reset_zero_a: assert property ($fell(I_SRST) |-> O_IRQ_ENABLE == 8'h00)
    else $error("enables not zero after reset");
  read_back_a: assert property (rd_c |-> O_READDATA[7:0] == O_IRQ_ENABLE)
    else $error("enable read back wrong");
  tx_hold_a: assert property (
    O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA)) else $error("tx word lost");
  cover property (wr_c);
  cover property (rd_c);
  cover property (O_TX_VALID && !I_TX_READY);
endmodule
bind serial_irq_enable_clear_and_data serial_irq_enable_clear_and_data_monitor i_mon (.*);
`default_nettype wire

// file: serial_irq_enable_clear_and_data_tb.sv
// Purpose: self-checking bench for the serial register block
// Assumes: avalon-mm master tasks, core model on the word ports
// Notes: flag reads before data access keep software ordering
`default_nettype none
module serial_irq_enable_clear_and_data_tb
  import serial_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, rd_s = 0, wr_s = 0, wreq, txv, txr, rxv;
  logic [7:0] adr = 0, en;
  logic [31:0] wd = 0, rdat, d;
  logic [4:0] evt = 0;
  logic [DATA_WIDTH-1:0] txd, rxd;
  logic [DATA_WIDTH-1:0] rxw[2] = '{9'h1a5, 9'h100};
  int miscompares = 0, compares = 0;
  serial_irq_enable_clear_and_data i_serial_irq_enable_clear_and_data (
    .I_SYS_CLK(clk), .I_SRST(srst), .I_ADDRESS(adr), .I_READ(rd_s), .I_WRITE(wr_s),
    .I_WRITEDATA(wd), .I_BYTEENABLE(4'hf), .O_READDATA(rdat), .O_WAITREQUEST(wreq),
    .O_RESPONSE(), .O_TX_VALID(txv), .O_TX_DATA(txd), .I_TX_READY(txr), .I_RX_VALID(rxv),
    .I_RX_DATA(rxd), .I_EVT_RX_START(evt[0]), .I_EVT_CTS_CHANGE(evt[1]),
    .I_EVT_RX_BREAK(evt[2]), .I_EVT_ERROR(evt[3]), .I_EVT_TX_DONE(evt[4]),
    .O_IRQ_ENABLE_ERROR(), .O_IRQ_ENABLE());
  serial_core_model i_serial_core_model (.clk(clk), .tx_valid(txv), .tx_data(txd),
    .tx_ready(txr), .rx_valid(rxv), .rx_data(rxd));
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // one access; the request stands until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    adr <= a;
    wd <= v;
    wr_s <= w;
    rd_s <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    d = rdat;
    wr_s <= 0;
    rd_s <= 0;
    if (wreq !== 1'b0) begin
      miscompares++;
      close_out();
    end
    @(posedge clk);
  endtask
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    bus(0, OFS_IRQ_ENABLE_CLEAR, 0); chk(d, 0);
    bus(1, OFS_IRQ_ENABLE_SET, 32'hff);
    bus(1, OFS_IRQ_ENABLE_CLEAR, 0);
    bus(0, OFS_IRQ_ENABLE_CLEAR, 0); chk(d, 32'hbf);
    en = 8'hbf;
    for (int b = 7; b >= 0; b--) begin
      bus(1, OFS_IRQ_ENABLE_CLEAR, 32'h1 << b);
      en = en & ~(8'h1 << b);
      bus(0, OFS_IRQ_ENABLE_SET, 0); chk(d, {24'h0, en});
    end
    bus(0, 8'h30, 0); chk(d, 0);
    for (int b = 0; b < 5; b++) begin
      evt <= 5'h1 << b;
      @(posedge clk);
    end
    evt <= 0;
    foreach (rxw[i]) begin
      i_serial_core_model.send(rxw[i]);
      bus(0, OFS_IRQ_FLAG, 0); chk(d & 32'h4, 32'h4);
      bus(0, OFS_SERIAL_DATA, 0); chk(d, {23'h0, rxw[i]});
    end
    // stall the core so the first word waits in the output stage and the second in the buffer
    i_serial_core_model.stall <= 1;
    foreach (rxw[i]) begin
      bus(0, OFS_IRQ_FLAG, 0); chk(d & 32'h1, 32'h1);
      bus(1, OFS_SERIAL_DATA, {23'h0, rxw[i] ^ 9'h0ff});
    end
    repeat (4) @(posedge clk);
    i_serial_core_model.stall <= 0;
    for (int n = 0; n < 50 && i_serial_core_model.got.size() < 2; n++) @(posedge clk);
    chk(i_serial_core_model.got.size(), 2);
    foreach (rxw[i]) chk(i_serial_core_model.got[i], rxw[i] ^ 9'h0ff);
    bus(1, OFS_IRQ_ENABLE_SET, 32'hff);
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    bus(0, OFS_IRQ_ENABLE_CLEAR, 0); chk(d, 0);
    close_out();
  end
endmodule
`default_nettype wire

// file: serial_regs_pkg.sv
// Purpose: shared constants and carriers for the serial port register block
// Assumes: 32-bit avalon-mm register bus, byte addresses
// Notes: offsets of the enable set and flag registers are local choices
`default_nettype none
package serial_regs_pkg;
  localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h18;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h1c;
  localparam logic [7:0] OFS_SERIAL_DATA = 8'h28;
  localparam int BIT_EMPTY = 0;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX_DONE = 2;
  localparam int BIT_RX_START = 3;
  localparam int BIT_CTS_CHANGE = 4;
  localparam int BIT_RX_BREAK = 5;
  localparam int BIT_RESERVED = 6;
  localparam int BIT_ERROR = 7;
  localparam logic [7:0] ENABLE_IMPL_MASK = 8'hbf;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam int DATA_WIDTH = 9;
  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic valid;
    logic [DATA_WIDTH-1:0] data;
  } word_s;

  typedef struct packed {
    logic rx_start;
    logic cts_change;
    logic rx_break;
    logic error;
    logic tx_done;
  } events_s;
endpackage
`default_nettype wire

// file: word_buffer.sv
// Purpose: two-entry valid/ready buffer for serial data words
// Assumes: single clock, synchronous active-high reset
// Notes: full and empty are exact; ready drops when both slots hold data
`default_nettype none
module word_buffer
  import serial_regs_pkg::*;
#(
  parameter int WIDTH = DATA_WIDTH,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire
